// File: logic/mmap_ports_pkg.sv
// shared constants and types for the memory map and port block
package mmap_ports_pkg;
	// cpu address map
	localparam logic [15:0] ROM_SMALL_BASE = 16'hD800;
	localparam logic [15:0] ROM_LARGE_BASE = 16'hC000;
	localparam logic [15:0] SPECIAL_BASE = 16'hFF00;
	localparam logic [15:0] VECTOR_BASE = 16'hFFF4;
	localparam logic [15:0] ZP_END = 16'h00FF;
	localparam logic [15:0] RAM0_END = 16'h00BF;
	localparam logic [15:0] RAM1_BASE = 16'h0100;
	localparam logic [15:0] RAM1_END = 16'h013F;
	localparam logic [15:0] PERIPH_BASE = 16'h00C0;
	localparam logic [15:0] SERIAL_MODE_CPU_ADDR = 16'h00F6;
	// apb register byte offsets
	localparam logic [11:0] OFS_HV_A = 12'h000;
	localparam logic [11:0] OFS_HV_B = 12'h004;
	localparam logic [11:0] OFS_HV_C = 12'h008;
	localparam logic [11:0] OFS_BIDIR_A_DATA = 12'h00C;
	localparam logic [11:0] OFS_BIDIR_A_DIR = 12'h010;
	localparam logic [11:0] OFS_BIDIR_B_DATA = 12'h014;
	localparam logic [11:0] OFS_BIDIR_B_DIR = 12'h018;
	localparam logic [11:0] OFS_MIXED = 12'h01C;
	localparam logic [11:0] OFS_CMOS_DATA = 12'h020;
	localparam logic [11:0] OFS_CMOS_DIR = 12'h024;
	localparam logic [11:0] OFS_SERIAL_MODE = 12'h028;
	localparam logic [11:0] OFS_CMOS_ALT = 12'h02C;
	// field positions
	localparam int SERIAL_EN_BIT = 2;
	localparam int SER_RDY_BIT = 7;
	localparam int SER_CLK_BIT = 6;
	localparam int SER_TX_BIT = 5;
	localparam int SER_RX_BIT = 4;
	localparam int CMP_BIT = 3;
	localparam int T3CLK_BIT = 2;
	localparam int IRQ_SECOND_BIT = 2;
	localparam int IRQ_FIRST_BIT = 3;
	localparam int MIXED_IN_LO = 2;
	localparam int MIXED_IN_HI = 7;
	localparam int MIXED_OUT_HI = 1;
	localparam int CMOS_W = 6;
	localparam int CMOS_ALT_W = 4;
	localparam int SYNC_STAGES = 2;
	// reset pulse that the outside must give
	localparam int RESET_LOW_NS = 2000;
	localparam int CLOCK_NS = 25;
	localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLOCK_NS - 1) / CLOCK_NS;
	// decoded region of one cpu address
	typedef struct packed {
		logic romSel;
		logic specialPage;
		logic vectorSel;
		logic zeroPage;
		logic ramSel;
		logic periphSel;
		logic stackRamSel;
		logic unmapped;
	} region_t;
	// serial unit outputs routed onto port b
	typedef struct packed {
		logic ready;
		logic clk;
		logic tx;
	} serial_out_t;
endpackage

// File: logic/port_bidir.sv
// one bidirectional port with per-pin direction and alternate outputs
module port_bidir
	import mmap_ports_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter bit OPEN_DRAIN = 1'b1
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// software side
	input wire logic [WIDTH-1:0] dataOut,
	input wire logic [WIDTH-1:0] dirOut,
	// alternate function
	input wire logic [WIDTH-1:0] altEn,
	input wire logic [WIDTH-1:0] altDir,
	input wire logic [WIDTH-1:0] altOut,
	// pad
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut,
	output logic [WIDTH-1:0] pinOe,
	output logic [WIDTH-1:0] pinSync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] oe_q;

	// alternate function overrides the general io bit by bit
	wire [WIDTH-1:0] effOut = (altEn & altOut) | (~altEn & dataOut);
	wire [WIDTH-1:0] effDir = (altEn & altDir) | (~altEn & dirOut);
	// open drain only ever pulls low; cmos drives both levels
	wire [WIDTH-1:0] out_d = OPEN_DRAIN ? '0 : effOut;
	wire [WIDTH-1:0] oe_d = OPEN_DRAIN ? (effDir & ~effOut) : effDir;

	// pad drivers, all released while in reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			out_q <= '0;
			oe_q <= '0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// two-stage synchroniser on the pad level
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign pinOut = out_q;
	assign pinOe = oe_q;
	assign pinSync = sync_q;
endmodule

// File: logic/mem_decoder.sv
// cpu address decoder for rom, ram, zero page and peripheral ranges
module mem_decoder
	import mmap_ports_pkg::*;
#(
	parameter bit LARGE_ROM = 1'b0
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// cpu side
	input wire logic [15:0] cpuAddr,
	input wire logic stackAccess,
	// decoded region, one cycle later
	output region_t region
);
	region_t region_q;

	// range compares
	wire [15:0] romBase = LARGE_ROM ? ROM_LARGE_BASE : ROM_SMALL_BASE;
	wire romHit = cpuAddr >= romBase;
	wire specialHit = cpuAddr >= SPECIAL_BASE;
	wire vectorHit = cpuAddr >= VECTOR_BASE;
	wire zpHit = cpuAddr <= ZP_END;
	wire ram0Hit = cpuAddr <= RAM0_END;
	wire ram1Hit = cpuAddr >= RAM1_BASE && cpuAddr <= RAM1_END;
	wire periphHit = cpuAddr >= PERIPH_BASE && zpHit;
	// the stack only ever lands in page zero ram
	wire stackHit = stackAccess && ram0Hit;
	wire noHit = !(romHit || ram0Hit || ram1Hit || periphHit);

	// register the decoded region
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			region_q <= '0;
		end else begin
			region_q.romSel <= romHit;
			region_q.specialPage <= specialHit;
			region_q.vectorSel <= vectorHit;
			region_q.zeroPage <= zpHit;
			region_q.ramSel <= ram0Hit || ram1Hit;
			region_q.periphSel <= periphHit;
			region_q.stackRamSel <= stackHit;
			region_q.unmapped <= noHit;
		end
	end

	assign region = region_q;

	property p_rom_range;
		@(posedge clock) disable iff (!resetn)
		1'b1 |=> (region.romSel == ($past(cpuAddr) >= romBase));
	endproperty
	a_rom_range: assert property (p_rom_range)
		else $error("rom select does not match rom range");

	property p_special_page;
		@(posedge clock) disable iff (!resetn)
		(cpuAddr >= SPECIAL_BASE) |=> region.specialPage && region.romSel;
	endproperty
	a_special_page: assert property (p_special_page)
		else $error("special page not decoded inside rom");

	property p_vector_area;
		@(posedge clock) disable iff (!resetn)
		region.vectorSel |-> region.specialPage && region.romSel;
	endproperty
	a_vector_area: assert property (p_vector_area)
		else $error("vector area outside special page");

	property p_page_one_ram;
		@(posedge clock) disable iff (!resetn)
		(cpuAddr >= RAM1_BASE && cpuAddr <= RAM1_END)
			|=> region.ramSel && !region.zeroPage;
	endproperty
	a_page_one_ram: assert property (p_page_one_ram)
		else $error("page one ram not decoded");

	property p_stack_page_zero;
		@(posedge clock) disable iff (!resetn)
		region.stackRamSel |-> region.ramSel && region.zeroPage
			&& !region.periphSel;
	endproperty
	a_stack_page_zero: assert property (p_stack_page_zero)
		else $error("stack access outside page zero ram");

	property p_periph_range;
		@(posedge clock) disable iff (!resetn)
		(cpuAddr >= PERIPH_BASE && cpuAddr <= ZP_END)
			|=> region.periphSel && region.zeroPage && !region.ramSel;
	endproperty
	a_periph_range: assert property (p_periph_range)
		else $error("peripheral range decoded wrongly");
endmodule

// File: logic/mmap_ports.sv
// memory map decoder and port pins with an apb register slave
//
// Function
// - output-only ports and two port bits reset low
// - first bidir port per-pin direction, inputs after reset
// - second bidir port same, plus alternate functions
// - serial mode puts ready, clock, out, in on port
// - bit 3 feeds comparator, bit 2 timer clock
// - mixed bits 2,3 feed interrupts; 4-7 plain inputs
// - six-pin cmos port with per-pin direction
// - cmos pins 0-3 selectable timer and pwm outputs
// - small variant rom from D800 to FFFF
// - large variant rom from C000 to FFFF
// - FF00 to FFFF is the special page
// - FFF4 to FFFF holds reset and interrupt vectors
// - 0000 to 00FF zero page holds ram, peripherals
// - ram at 0000-00BF and 0100-013F, 256 bytes
// - stack uses only page zero ram
// - serial mode bit 2 enables serial pins
//
// The implementer's own choices: the APB slave port and the register offsets.
module mmap_ports
	import mmap_ports_pkg::*;
#(
	parameter bit LARGE_ROM = 1'b0
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	// cpu address decode
	input wire logic [15:0] cpuAddr,
	input wire logic stackAccess,
	output region_t region,
	// high-voltage output ports
	output logic [7:0] hvOutPortA,
	output logic [7:0] hvOutPortB,
	output logic [7:0] hvOutPortC,
	// first bidirectional port
	input wire logic [7:0] bidirPortAIn,
	output logic [7:0] bidirPortAOut,
	output logic [7:0] bidirPortAOe,
	// second bidirectional port
	input wire logic [7:0] bidirPortBIn,
	output logic [7:0] bidirPortBOut,
	output logic [7:0] bidirPortBOe,
	// mixed port
	input wire logic [MIXED_IN_HI:MIXED_IN_LO] mixedPortEIn,
	output logic [MIXED_OUT_HI:0] mixedPortEOut,
	// cmos bidirectional port
	input wire logic [CMOS_W-1:0] cmosBidirPortIn,
	output logic [CMOS_W-1:0] cmosBidirPortOut,
	output logic [CMOS_W-1:0] cmosBidirPortOe,
	// peripheral signals routed to pins
	input wire serial_out_t serialIo,
	input wire logic timerOut,
	input wire logic pulseWidthOutA,
	input wire logic pulseWidthOutB,
	input wire logic pulseWidthOutC,
	// serial enable bit and pin levels delivered to peripherals
	output logic serialEnable,
	output logic serialRxPin,
	output logic comparatorIn,
	output logic timer3ClockIn,
	output logic extIrqFirst,
	output logic extIrqSecond
);
	logic pready_q;
	logic [31:0] prdata_q;
	logic [7:0] hvA_q;
	logic [7:0] hvB_q;
	logic [7:0] hvC_q;
	logic [MIXED_OUT_HI:0] mixOut_q;
	logic [7:0] bidirAData_q;
	logic [7:0] bidirADir_q;
	logic [7:0] bidirBData_q;
	logic [7:0] bidirBDir_q;
	logic [CMOS_W-1:0] cmosData_q;
	logic [CMOS_W-1:0] cmosDir_q;
	logic [CMOS_ALT_W-1:0] cmosAlt_q;
	logic [7:0] serialMode_q;
	logic [MIXED_IN_HI:MIXED_IN_LO] mixMeta_q;
	logic [MIXED_IN_HI:MIXED_IN_LO] mixSync_q;
	logic [1:0] liveCnt_q;
	logic [7:0] syncA;
	logic [7:0] syncB;
	logic [CMOS_W-1:0] syncCmos;

	// apb handshake: one wait cycle, write lands with pready high
	wire access = psel && penable;
	wire pready_d = access && !pready_q;
	wire doWrite = access && pready_q && pwrite;
	wire readLoad = access && !pready_q && !pwrite;

	// register selects
	wire selHvA = paddr == OFS_HV_A;
	wire selHvB = paddr == OFS_HV_B;
	wire selHvC = paddr == OFS_HV_C;
	wire selADat = paddr == OFS_BIDIR_A_DATA;
	wire selADir = paddr == OFS_BIDIR_A_DIR;
	wire selBDat = paddr == OFS_BIDIR_B_DATA;
	wire selBDir = paddr == OFS_BIDIR_B_DIR;
	wire selMix = paddr == OFS_MIXED;
	wire selCDat = paddr == OFS_CMOS_DATA;
	wire selCDir = paddr == OFS_CMOS_DIR;
	wire selSer = paddr == OFS_SERIAL_MODE;
	wire selAlt = paddr == OFS_CMOS_ALT;
	wire regHit = selHvA || selHvB || selHvC || selADat || selADir
		|| selBDat || selBDir || selMix || selCDat || selCDir
		|| selSer || selAlt;

	// port data reads: output bits show the latch, input bits the pin
	wire [7:0] readA = (bidirADir_q & bidirAData_q) | (~bidirADir_q & syncA);
	wire [7:0] readB = (bidirBDir_q & bidirBData_q) | (~bidirBDir_q & syncB);
	wire [CMOS_W-1:0] readC = (cmosDir_q & cmosData_q)
		| (~cmosDir_q & syncCmos);
	wire [7:0] readMix = {mixSync_q, mixOut_q};

	// read mux, unmapped offsets read zero
	wire [7:0] rdByte = ({8{selHvA}} & hvA_q)
		| ({8{selHvB}} & hvB_q)
		| ({8{selHvC}} & hvC_q)
		| ({8{selADat}} & readA)
		| ({8{selADir}} & bidirADir_q)
		| ({8{selBDat}} & readB)
		| ({8{selBDir}} & bidirBDir_q)
		| ({8{selMix}} & readMix)
		| ({8{selCDat}} & {2'h0, readC})
		| ({8{selCDir}} & {2'h0, cmosDir_q})
		| ({8{selSer}} & serialMode_q)
		| ({8{selAlt}} & {4'h0, cmosAlt_q});

	// apb answer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= pready_d;
			if (readLoad) begin
				prdata_q <= {24'h000000, rdByte};
			end
		end
	end

	// output-only latches, driven low from reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hvA_q <= '0;
			hvB_q <= '0;
			hvC_q <= '0;
			mixOut_q <= '0;
		end else if (doWrite) begin
			if (selHvA) hvA_q <= pwdata[7:0];
			if (selHvB) hvB_q <= pwdata[7:0];
			if (selHvC) hvC_q <= pwdata[7:0];
			if (selMix) mixOut_q <= pwdata[MIXED_OUT_HI:0];
		end
	end

	// bidir port latches; all directions clear to input at reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bidirAData_q <= '0;
			bidirADir_q <= '0;
			bidirBData_q <= '0;
			bidirBDir_q <= '0;
		end else if (doWrite) begin
			if (selADat) bidirAData_q <= pwdata[7:0];
			if (selADir) bidirADir_q <= pwdata[7:0];
			if (selBDat) bidirBData_q <= pwdata[7:0];
			if (selBDir) bidirBDir_q <= pwdata[7:0];
		end
	end

	// cmos port latches, alternate select and serial mode
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmosData_q <= '0;
			cmosDir_q <= '0;
			cmosAlt_q <= '0;
			serialMode_q <= '0;
		end else if (doWrite) begin
			if (selCDat) cmosData_q <= pwdata[CMOS_W-1:0];
			if (selCDir) cmosDir_q <= pwdata[CMOS_W-1:0];
			if (selAlt) cmosAlt_q <= pwdata[CMOS_ALT_W-1:0];
			if (selSer) serialMode_q <= pwdata[7:0];
		end
	end

	// mixed input synchroniser and settle counter for checks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mixMeta_q <= '0;
			mixSync_q <= '0;
			liveCnt_q <= '0;
		end else begin
			mixMeta_q <= mixedPortEIn;
			mixSync_q <= mixMeta_q;
			if (liveCnt_q != 2'h3) liveCnt_q <= liveCnt_q + 2'h1;
		end
	end

	// serial takes over the top four bits of the second port
	wire serialOn = serialMode_q[SERIAL_EN_BIT];
	wire [7:0] altEnB = serialOn ? 8'hF0 : 8'h00;
	wire [7:0] altDirB = 8'hE0;
	wire [7:0] altOutB = {serialIo.ready, serialIo.clk, serialIo.tx,
		5'h00};

	// cmos pins 0 to 3 carry timer and pwm outputs when selected
	wire [CMOS_W-1:0] altEnC = {2'h0, cmosAlt_q};
	wire [CMOS_W-1:0] altDirC = 6'h0F;
	wire [CMOS_W-1:0] altOutC = {2'h0, pulseWidthOutC, pulseWidthOutB,
		pulseWidthOutA, timerOut};

	// first open-drain port, general io only
	port_bidir #(.WIDTH(8), .OPEN_DRAIN(1'b1)) portA (
		.clock(clock),
		.resetn(resetn),
		.dataOut(bidirAData_q),
		.dirOut(bidirADir_q),
		.altEn(8'h00),
		.altDir(8'h00),
		.altOut(8'h00),
		.pinIn(bidirPortAIn),
		.pinOut(bidirPortAOut),
		.pinOe(bidirPortAOe),
		.pinSync(syncA)
	);

	// second open-drain port with serial functions
	port_bidir #(.WIDTH(8), .OPEN_DRAIN(1'b1)) portB (
		.clock(clock),
		.resetn(resetn),
		.dataOut(bidirBData_q),
		.dirOut(bidirBDir_q),
		.altEn(altEnB),
		.altDir(altDirB),
		.altOut(altOutB),
		.pinIn(bidirPortBIn),
		.pinOut(bidirPortBOut),
		.pinOe(bidirPortBOe),
		.pinSync(syncB)
	);

	// cmos tri-state port
	port_bidir #(.WIDTH(CMOS_W), .OPEN_DRAIN(1'b0)) portC (
		.clock(clock),
		.resetn(resetn),
		.dataOut(cmosData_q),
		.dirOut(cmosDir_q),
		.altEn(altEnC),
		.altDir(altDirC),
		.altOut(altOutC),
		.pinIn(cmosBidirPortIn),
		.pinOut(cmosBidirPortOut),
		.pinOe(cmosBidirPortOe),
		.pinSync(syncCmos)
	);

	// cpu address decoder
	mem_decoder #(.LARGE_ROM(LARGE_ROM)) decoder (
		.clock(clock),
		.resetn(resetn),
		.cpuAddr(cpuAddr),
		.stackAccess(stackAccess),
		.region(region)
	);

	// outputs
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign hvOutPortA = hvA_q;
	assign hvOutPortB = hvB_q;
	assign hvOutPortC = hvC_q;
	assign mixedPortEOut = mixOut_q;
	assign serialEnable = serialMode_q[SERIAL_EN_BIT];
	assign serialRxPin = syncB[SER_RX_BIT];
	assign comparatorIn = syncB[CMP_BIT];
	assign timer3ClockIn = syncB[T3CLK_BIT];
	assign extIrqFirst = mixSync_q[IRQ_FIRST_BIT];
	assign extIrqSecond = mixSync_q[IRQ_SECOND_BIT];

	property p_hv_hold;
		@(posedge clock) disable iff (!resetn)
		!(doWrite && selHvA) |=> $stable(hvOutPortA);
	endproperty
	a_hv_hold: assert property (p_hv_hold)
		else $error("output port changed without a write");

	property p_input_after_reset;
		@(posedge clock) disable iff (!resetn)
		!(|bidirADir_q) |=> !(|bidirPortAOe);
	endproperty
	a_input_after_reset: assert property (p_input_after_reset)
		else $error("port a drives a pin set as input");

	property p_serial_pins;
		@(posedge clock) disable iff (!resetn)
		(serialOn && !serialIo.tx) |=> bidirPortBOe[SER_TX_BIT]
			&& !bidirPortBOe[SER_RX_BIT];
	endproperty
	a_serial_pins: assert property (p_serial_pins)
		else $error("serial pins not taken over");

	property p_irq_follow;
		@(posedge clock) disable iff (!resetn)
		(liveCnt_q == 2'h3) |->
			extIrqFirst == $past(mixedPortEIn[IRQ_FIRST_BIT], 2);
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("first interrupt input lags wrongly");

	property p_timer_pin;
		@(posedge clock) disable iff (!resetn)
		(cmosAlt_q[0] && cmosDir_q[0] == 1'b0) |=>
			cmosBidirPortOe[0] && cmosBidirPortOut[0] == $past(timerOut);
	endproperty
	a_timer_pin: assert property (p_timer_pin)
		else $error("timer output not on cmos pin 0");

	property p_unmapped_zero;
		@(posedge clock) disable iff (!resetn)
		(readLoad && !regHit) |=> pready && prdata == 32'h00000000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read returned data");
endmodule

// File: verification/port_pins_model.sv
// outside circuitry on the port pins: pull-ups and remote drivers
module port_pins_model
	import mmap_ports_pkg::*;
(
	// design pin drivers
	input wire logic [7:0] aOe,
	input wire logic [7:0] bOe,
	input wire logic [CMOS_W-1:0] cOut,
	input wire logic [CMOS_W-1:0] cOe,
	// levels the outside puts on the pins
	input wire logic [7:0] aExt,
	input wire logic [7:0] bExt,
	input wire logic [CMOS_W-1:0] cExt,
	// resolved pin levels
	output logic [7:0] aPin,
	output logic [7:0] bPin,
	output logic [CMOS_W-1:0] cPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// open-drain lines idle high through pull-ups; any party may pull low
	assign aPin = aExt & ~aOe;
	assign bPin = bExt & ~bOe;
	// push-pull pins follow the driver while enabled, else the outside
	assign cPin = (cOe & cOut) | (~cOe & cExt);
endmodule

// File: verification/tb_mmap_ports.sv
// self-checking bench for the memory map and port block
module tb_mmap_ports
	import mmap_ports_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic pready;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [15:0] cpuAddr = 16'h0000;
	logic stackAccess = 1'b0;
	region_t region;
	region_t regionLarge;
	logic [7:0] hvA, hvB, hvC, aIn, aOut, aOe, bIn, bOut, bOe;
	logic [7:0] aExt = 8'hFF;
	logic [7:0] bExt = 8'hFF;
	logic [7:2] eIn = 6'h00;
	logic [1:0] eOut;
	logic [5:0] cIn, cOut, cOe;
	logic [5:0] cExt = 6'h00;
	serial_out_t serialIo = 3'h0;
	logic timerOut = 1'b0;
	logic pwA = 1'b0;
	logic pwB = 1'b0;
	logic pwC = 1'b0;
	logic serEn, rxPin, cmpIn, t3Clk, irq1, irq2;
	int n_errors = 0;
	int total_checks = 0;
	logic [15:0] tbl [16] = '{16'h0000, 16'h00BF, 16'h00C0, 16'h00F6,
		16'h00FF, 16'h0100, 16'h013F, 16'h0140, 16'hC000, 16'hD7FF,
		16'hD800, 16'hFEFF, 16'hFF00, 16'hFFF3, 16'hFFF4, 16'hFFFF};

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// device under test, a large-rom copy of the block, and the pins
	mmap_ports i_dut (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .cpuAddr(cpuAddr),
		.stackAccess(stackAccess), .region(region), .hvOutPortA(hvA),
		.hvOutPortB(hvB), .hvOutPortC(hvC), .bidirPortAIn(aIn),
		.bidirPortAOut(aOut), .bidirPortAOe(aOe), .bidirPortBIn(bIn),
		.bidirPortBOut(bOut), .bidirPortBOe(bOe), .mixedPortEIn(eIn),
		.mixedPortEOut(eOut), .cmosBidirPortIn(cIn),
		.cmosBidirPortOut(cOut), .cmosBidirPortOe(cOe),
		.serialIo(serialIo), .timerOut(timerOut), .pulseWidthOutA(pwA),
		.pulseWidthOutB(pwB), .pulseWidthOutC(pwC), .serialEnable(serEn),
		.serialRxPin(rxPin), .comparatorIn(cmpIn), .timer3ClockIn(t3Clk),
		.extIrqFirst(irq1), .extIrqSecond(irq2));
	mmap_ports #(.LARGE_ROM(1'b1)) i_dut_large (.clock(clock),
		.resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(),
		.prdata(), .cpuAddr(cpuAddr), .stackAccess(stackAccess),
		.region(regionLarge), .hvOutPortA(), .hvOutPortB(),
		.hvOutPortC(), .bidirPortAIn(aIn), .bidirPortAOut(),
		.bidirPortAOe(), .bidirPortBIn(bIn), .bidirPortBOut(),
		.bidirPortBOe(), .mixedPortEIn(eIn), .mixedPortEOut(),
		.cmosBidirPortIn(cIn), .cmosBidirPortOut(),
		.cmosBidirPortOe(), .serialIo(serialIo), .timerOut(timerOut),
		.pulseWidthOutA(pwA), .pulseWidthOutB(pwB),
		.pulseWidthOutC(pwC), .serialEnable(), .serialRxPin(),
		.comparatorIn(), .timer3ClockIn(), .extIrqFirst(),
		.extIrqSecond());
	port_pins_model i_pins (.aOe(aOe), .bOe(bOe), .cOut(cOut), .cOe(cOe),
		.aExt(aExt), .bExt(bExt), .cExt(cExt), .aPin(aIn), .bPin(bIn),
		.cPin(cIn));

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// compare one value against its expectation
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_errors++;
			$display("BAD %0t apb timeout", $time);
			end_sim();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read");
	endtask

	// let register, pin synchronisers and pin outputs land
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask

	// expected decode of one cpu address
	function automatic region_t exp_region(input logic [15:0] a,
		input logic s, input logic lg);
		region_t r;
		r.romSel = a >= (lg ? ROM_LARGE_BASE : ROM_SMALL_BASE);
		r.specialPage = a >= SPECIAL_BASE;
		r.vectorSel = a >= VECTOR_BASE;
		r.zeroPage = a <= ZP_END;
		r.ramSel = a <= RAM0_END || (a >= RAM1_BASE && a <= RAM1_END);
		r.periphSel = a >= PERIPH_BASE && a <= ZP_END;
		r.stackRamSel = s && a <= RAM0_END;
		r.unmapped = !(r.romSel || r.ramSel || r.periphSel);
		return r;
	endfunction

	task automatic t_reset();
		chk({hvA, hvB, hvC, 6'h0, eOut}, 32'h0, "reset lvl");
		chk({8'h0, aOe, bOe, 2'h0, cOe}, 32'h0, "reset oe");
		rdchk(OFS_BIDIR_A_DIR, 32'h0);
		rdchk(OFS_BIDIR_B_DIR, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_hv();
		apb(1'b1, OFS_HV_A, 32'hA5);
		apb(1'b1, OFS_HV_B, 32'hFFFF_FF5A);
		apb(1'b1, OFS_HV_C, 32'h3C);
		settle();
		chk({hvA, hvB, hvC}, 32'hA55A3C, "hv ports");
		rdchk(OFS_HV_B, 32'h5A);
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		#1;
		chk({hvA, hvB, hvC}, 32'h0, "hv in reset");
		repeat (RESET_LOW_CYCLES + 1) @(posedge clock);
		resetn <= 1'b1;
		$display("test hv ports done");
	endtask

	task automatic t_port_a();
		apb(1'b1, OFS_BIDIR_A_DATA, 32'h05);
		apb(1'b1, OFS_BIDIR_A_DIR, 32'h0F);
		aExt <= 8'hC3;
		settle();
		chk({aOut, aOe}, 32'h000A, "port a oe");
		rdchk(OFS_BIDIR_A_DATA, 32'h05 | (8'hF0 & 8'hC3 & ~8'h0A));
		apb(1'b1, OFS_BIDIR_A_DIR, 32'hF0);
		settle();
		chk(aOe, 8'hF0, "port a dir");
		$display("test port a done");
	endtask

	task automatic t_port_b();
		apb(1'b1, OFS_BIDIR_B_DATA, 32'h01);
		apb(1'b1, OFS_BIDIR_B_DIR, 32'h03);
		apb(1'b1, OFS_SERIAL_MODE, 32'h04);
		serialIo <= 3'b101;
		bExt <= 8'h14;
		settle();
		chk({bOut, bOe}, 32'h0042, "serial oe");
		chk({serEn, rxPin, cmpIn, t3Clk}, 4'hD, "serial in");
		serialIo <= 3'b010;
		bExt <= 8'h08;
		settle();
		chk(bOe, 8'hA2, "serial oe2");
		chk({rxPin, cmpIn, t3Clk}, 3'b010, "pin feeds");
		apb(1'b1, OFS_SERIAL_MODE, 32'h00);
		settle();
		chk({serEn, bOe}, 9'h002, "serial off");
		$display("test port b done");
	endtask

	task automatic t_mixed();
		eIn <= 6'h2A;
		settle();
		chk({irq1, irq2}, 2'b10, "irq a");
		eIn <= 6'h15;
		apb(1'b1, OFS_MIXED, 32'hFE);
		settle();
		chk({irq1, irq2, eOut}, 4'h6, "irq b");
		rdchk(OFS_MIXED, {24'h0, 6'h15, 2'b10});
		$display("test mixed port done");
	endtask

	task automatic t_cmos();
		timerOut <= 1'b1;
		pwB <= 1'b1;
		apb(1'b1, OFS_CMOS_DATA, 32'h2A);
		apb(1'b1, OFS_CMOS_DIR, 32'h30);
		apb(1'b1, OFS_CMOS_ALT, 32'h0F);
		settle();
		chk({cOe, cOut}, {6'h3F, 6'h25}, "alt out");
		timerOut <= 1'b0;
		pwA <= 1'b1;
		pwB <= 1'b0;
		settle();
		chk(cOut, 6'h22, "pwm a");
		pwA <= 1'b0;
		pwC <= 1'b1;
		settle();
		chk(cOut, 6'h28, "pwm c");
		apb(1'b1, OFS_CMOS_ALT, 32'h00);
		cExt <= 6'h0C;
		settle();
		chk({cOe, cOut & cOe}, {6'h30, 6'h20}, "cmos out");
		rdchk(OFS_CMOS_DATA, 32'h2C);
		$display("test cmos port done");
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h030, 32'hFF);
		rdchk(12'h030, 32'h0);
		rdchk(OFS_HV_A, 32'h0);
		$display("test unmapped done");
	endtask

	task automatic t_decode();
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			cpuAddr <= tbl[i];
			stackAccess <= i[0];
			@(posedge clock);
			#1;
			chk(region, exp_region(tbl[i], i[0], 1'b0), "dec");
			chk(regionLarge, exp_region(tbl[i], i[0], 1'b1), "dec l");
		end
		$display("test decode done");
	endtask

	// main sequence
	initial begin
		repeat (RESET_LOW_CYCLES + 1) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		#1;
		t_reset();
		t_hv();
		t_port_a();
		t_port_b();
		t_mixed();
		t_cmos();
		t_unmapped();
		t_decode();
		end_sim();
	end
endmodule
